// ---- hdl/bid_core.sv ----
// execute stage for jump, increment, increment-skip and or-literal
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - jump loads its 11-bit target into pc bits 10..0
// RULE2 - jump fills pc bits 12..11 from upper latch bits 4..3
// RULE3 - jump takes two cycles and changes no flags
// RULE4 - increment-skip adds one, writes accumulator if dest 0, else the register
// RULE5 - zero result flushes fetched next instruction as nop; no flags change
// RULE6 - or-literal ors literal into accumulator in one cycle, sets zero flag
// RULE7 - plain increment adds one, writes destination, sets zero flag, one cycle
module bid_core
  import bid_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_insn_valid,
  input wire logic [bid_pkg::INSN_W-1:0] i_insn,
  input wire logic [bid_pkg::PC_W-1:0] i_pc,
  input wire logic [bid_pkg::DATA_W-1:0] i_pc_upper_latch,
  input wire logic [bid_pkg::DATA_W-1:0] i_file_rdata,
  output logic [bid_pkg::FADDR_W-1:0] o_file_addr,
  output logic o_file_we,
  output logic [bid_pkg::DATA_W-1:0] o_file_wdata,
  output logic [bid_pkg::DATA_W-1:0] o_accum,
  output logic o_zero_we,
  output logic o_zero,
  output logic o_pc_load,
  output logic [bid_pkg::PC_W-1:0] o_pc,
  output logic o_flush,
  output logic o_busy
);
  import bid_pkg::*;

  // high when every bit of a data word is clear
  function automatic logic is_null(input logic [DATA_W-1:0] v);
    return (v == '0);
  endfunction : is_null

  // decoded opcode strobes
  wire logic is_jump;
  wire logic is_inc_skip;
  wire logic is_inc;
  wire logic is_or_lit;

  bid_decode u_decode (
    .i_insn(i_insn),
    .o_is_jump(is_jump),
    .o_is_inc_skip(is_inc_skip),
    .o_is_inc(is_inc),
    .o_is_or_lit(is_or_lit)
  );

  // state and output registers
  bid_state_t state_q;
  bid_state_t state_d;
  logic busy_q;
  logic busy_d;
  logic [FADDR_W-1:0] file_addr_q;
  logic [FADDR_W-1:0] file_addr_d;
  logic file_we_q;
  logic file_we_d;
  logic [DATA_W-1:0] file_wdata_q;
  logic [DATA_W-1:0] file_wdata_d;
  logic [DATA_W-1:0] accum_q;
  logic [DATA_W-1:0] accum_d;
  logic zero_we_q;
  logic zero_we_d;
  logic zero_q;
  logic zero_d;
  logic pc_load_q;
  logic pc_load_d;
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] pc_d;
  logic flush_q;
  logic flush_d;

  // an instruction executes only outside the flush cycle
  wire logic exec = i_insn_valid && (state_q == BID_EXEC);
  wire logic dest_file = i_insn[DEST_BIT];
  wire logic [FADDR_W-1:0] faddr = i_insn[FADDR_W-1:0];
  wire logic [DATA_W-1:0] lit_val = i_insn[DATA_W-1:0];

  wire logic do_jump = exec && is_jump;
  wire logic do_inc_skip = exec && is_inc_skip;
  wire logic do_inc = exec && is_inc;
  wire logic do_or_lit = exec && is_or_lit;
  wire logic do_any_inc = do_inc || do_inc_skip;

  // RULE4 RULE7 incremented operand
  wire logic [DATA_W-1:0] inc_sum = i_file_rdata + INC_ONE;
  wire logic inc_null = is_null(inc_sum);
  // RULE6 ored literal
  wire logic [DATA_W-1:0] or_res = accum_q | lit_val;
  wire logic or_null = is_null(or_res);
  // RULE1 RULE2 jump target
  wire logic [PC_W-1:0] jump_pc = {i_pc_upper_latch[LATCH_LO+1:LATCH_LO], i_insn[JUMP_TGT_W-1:0]};
  // RULE5 skip on null
  wire logic skip = do_inc_skip && inc_null;
  // RULE3 RULE5 second cycle
  wire logic need_flush = skip || do_jump;

  // RULE4 RULE7 file write back
  wire logic file_sel = do_any_inc && dest_file;
  // RULE4 RULE6 RULE7 accumulator write
  wire logic acc_sel = (do_any_inc && !dest_file) || do_or_lit;
  // RULE3 RULE5 RULE6 RULE7 zero flag owners
  wire logic zero_sel = do_inc || do_or_lit;

  assign file_we_d = file_sel;
  assign file_addr_d = faddr;
  assign file_wdata_d = inc_sum;
  assign accum_d = acc_sel ? (do_or_lit ? or_res : inc_sum) : accum_q;
  assign zero_we_d = zero_sel;
  assign zero_d = zero_sel ? (do_or_lit ? or_null : inc_null) : zero_q;
  assign pc_load_d = do_jump;
  assign pc_d = do_jump ? jump_pc : pc_q;
  assign flush_d = need_flush;
  assign busy_d = (state_d == BID_FLUSH);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      BID_EXEC: begin
        if (need_flush) begin
          state_d = BID_FLUSH;
        end
      end
      BID_FLUSH: begin
        state_d = BID_EXEC;
      end
      default: begin
        state_d = BID_EXEC;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      state_q <= BID_EXEC;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      file_we_q <= 1'b0;
    end else begin
      file_we_q <= file_we_d;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      file_addr_q <= '0;
    end else begin
      file_addr_q <= file_addr_d;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      file_wdata_q <= ACC_RST;
    end else begin
      file_wdata_q <= file_wdata_d;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      accum_q <= ACC_RST;
    end else begin
      accum_q <= accum_d;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      zero_we_q <= 1'b0;
    end else begin
      zero_we_q <= zero_we_d;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      zero_q <= 1'b0;
    end else begin
      zero_q <= zero_d;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      pc_load_q <= 1'b0;
    end else begin
      pc_load_q <= pc_load_d;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      pc_q <= PC_RST;
    end else begin
      pc_q <= pc_d;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      flush_q <= 1'b0;
    end else begin
      flush_q <= flush_d;
    end
  end

  assign o_file_addr = file_addr_q;
  assign o_file_we = file_we_q;
  assign o_file_wdata = file_wdata_q;
  assign o_accum = accum_q;
  assign o_zero_we = zero_we_q;
  assign o_zero = zero_q;
  assign o_pc_load = pc_load_q;
  assign o_pc = pc_q;
  assign o_flush = flush_q;
  assign o_busy = busy_q;
endmodule : bid_core

// ---- hdl/bid_pkg.sv ----
// constants for the four-instruction decode and execute block
package bid_pkg;
  localparam int unsigned INSN_W = 14;
  localparam int unsigned PC_W = 13;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FADDR_W = 7;
  // opcode patterns
  localparam logic [2:0] OPC_JUMP = 3'h5;
  localparam logic [5:0] OPC_INC_SKIP = 6'h0f;
  localparam logic [5:0] OPC_INC = 6'h0a;
  localparam logic [5:0] OPC_OR_LIT = 6'h38;
  // field positions
  localparam int unsigned OPC_MSB = 13;
  localparam int unsigned JUMP_OPC_LSB = 11;
  localparam int unsigned OPC_LSB = 8;
  localparam int unsigned JUMP_TGT_W = 11;
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned LATCH_LO = 3;
  // reset values and increment step
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic [DATA_W-1:0] INC_ONE = 8'h01;
  typedef enum logic [1:0] {
    BID_EXEC = 2'b00,
    BID_FLUSH = 2'b01
  } bid_state_t;
endpackage : bid_pkg

// ---- hdl/bid_decode.sv ----
// opcode decoder for the four supported instructions
`timescale 1ns/1ps
module bid_decode
  import bid_pkg::*;
(
  input wire logic [bid_pkg::INSN_W-1:0] i_insn,
  output logic o_is_jump,
  output logic o_is_inc_skip,
  output logic o_is_inc,
  output logic o_is_or_lit
);
  import bid_pkg::*;

  assign o_is_jump = (i_insn[OPC_MSB:JUMP_OPC_LSB] == OPC_JUMP);
  assign o_is_inc_skip = (i_insn[OPC_MSB:OPC_LSB] == OPC_INC_SKIP);
  assign o_is_inc = (i_insn[OPC_MSB:OPC_LSB] == OPC_INC);
  assign o_is_or_lit = (i_insn[OPC_MSB:OPC_LSB] == OPC_OR_LIT);
endmodule : bid_decode

// ---- verif/bid_chk.sv ----
// checker for the decode and execute block
`timescale 1ns/1ps
module bid_chk
  import bid_pkg::*;
(
  input logic i_core_clk,
  input logic i_nrst,
  input logic i_insn_valid,
  input logic [13:0] i_insn,
  input logic [7:0] i_pc_upper_latch,
  input logic [7:0] i_file_rdata,
  input logic o_file_we,
  input logic [7:0] o_file_wdata,
  input logic [7:0] o_accum,
  input logic o_zero_we,
  input logic o_zero,
  input logic o_pc_load,
  input logic [12:0] o_pc,
  input logic o_flush,
  input logic o_busy
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  wire tk = i_insn_valid && !o_busy;
  wire jmp = tk && i_insn[13:11] == OPC_JUMP;
  wire isk = tk && i_insn[13:8] == OPC_INC_SKIP;
  wire inc = tk && i_insn[13:8] == OPC_INC;
  wire orl = tk && i_insn[13:8] == OPC_OR_LIT;
  jump_low_a: assert property (jmp |=> o_pc_load && o_pc[10:0] == $past(i_insn[10:0]))
    else $error("jump target wrong");
  jump_high_a: assert property (jmp |=> o_pc[12:11] == $past(i_pc_upper_latch[4:3]))
    else $error("jump upper bits wrong");
  jump_cycles_a: assert property (jmp |=> o_busy && !o_zero_we ##1 !o_busy)
    else $error("jump length wrong");
  skip_write_a: assert property (isk && i_insn[7] |=> o_file_we && o_file_wdata == $past(i_file_rdata) + 8'h01)
    else $error("skip sum wrong");
  skip_flush_a: assert property (isk |=> o_flush == ($past(i_file_rdata) == 8'hff) && !o_zero_we)
    else $error("skip flush wrong");
  or_result_a: assert property (orl |=> o_zero_we && o_accum == ($past(o_accum) | $past(i_insn[7:0])))
    else $error("or result wrong");
  inc_zero_a: assert property (inc |=> o_zero_we && !o_flush && o_zero == ($past(i_file_rdata) == 8'hff))
    else $error("increment zero wrong");
endmodule : bid_chk

// ---- verif/branch_increment_or_decode_tb.sv ----
// testbench for the decode and execute block
`timescale 1ns/1ps
module branch_increment_or_decode_tb;
  logic i_core_clk = 1'h0, i_nrst = 1'h0, i_insn_valid = 1'h0;
  logic [13:0] i_insn = 14'h0000;
  logic [12:0] i_pc = 13'h0000, o_pc;
  logic [7:0] i_pc_upper_latch = 8'h00, i_file_rdata = 8'h00, o_file_wdata, o_accum;
  logic [6:0] o_file_addr;
  logic o_file_we, o_zero_we, o_zero, o_pc_load, o_flush, o_busy;
  logic [14:0] fw_seen = 15'h0000;
  int errors = 0, compares = 0;
  bid_core DUT (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_insn_valid(i_insn_valid),
    .i_insn(i_insn),
    .i_pc(i_pc),
    .i_pc_upper_latch(i_pc_upper_latch),
    .i_file_rdata(i_file_rdata),
    .o_file_addr(o_file_addr),
    .o_file_we(o_file_we),
    .o_file_wdata(o_file_wdata),
    .o_accum(o_accum),
    .o_zero_we(o_zero_we),
    .o_zero(o_zero),
    .o_pc_load(o_pc_load),
    .o_pc(o_pc),
    .o_flush(o_flush),
    .o_busy(o_busy)
  );
  initial forever #2 i_core_clk = ~i_core_clk;
  task automatic chk(input logic [23:0] got, exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // busy slot gets an or that must be ignored
  task automatic run(input logic [13:0] w, input logic [7:0] d, input logic [4:0] e);
    @(negedge i_core_clk);
    {i_insn, i_file_rdata, i_insn_valid} = {w, d, 1'h1};
    @(negedge i_core_clk);
    chk({o_pc_load, o_busy, o_flush, o_zero_we, o_file_we}, e);
    // write address and data only stand in the strobe cycle
    fw_seen = {o_file_addr, o_file_wdata};
    if (e[3]) begin
      i_insn = 14'h38ff;
      @(negedge i_core_clk);
    end
    i_insn_valid = 1'h0;
  endtask : run
  task automatic t_or;
    run(14'h3800, 8'h00, 5'h02);
    chk(o_zero, 1'h1);
    run(14'h389a, 8'h00, 5'h02);
    run(14'h3835, 8'h00, 5'h02);
    chk({o_zero, o_accum}, 9'h0bf);
    $display("or literal done");
  endtask : t_or
  task automatic t_jump;
    i_pc_upper_latch = 8'h18;
    run(14'h2923, 8'h00, 5'h1c);
    chk({o_pc, o_accum}, 21'h1923bf);
    i_pc_upper_latch = 8'h08;
    run(14'h2fff, 8'h00, 5'h1c);
    chk(o_pc, 13'h0fff);
    $display("jump done");
  endtask : t_jump
  task automatic t_skip;
    run(14'h0f85, 8'hff, 5'h0d);
    chk(fw_seen, 15'h0500);
    chk(o_accum, 8'hbf);
    run(14'h0f05, 8'h10, 5'h00);
    chk(o_accum, 8'h11);
    $display("increment skip done");
  endtask : t_skip
  task automatic t_inc;
    run(14'h0a85, 8'hff, 5'h03);
    chk({o_zero, o_file_wdata}, 9'h100);
    run(14'h0a05, 8'h41, 5'h02);
    chk({o_zero, o_accum}, 9'h042);
    $display("increment done");
  endtask : t_inc
  task automatic conclude;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (20) @(negedge i_core_clk);
    i_nrst = 1'h1;
    chk({o_pc_load, o_busy, o_flush, o_file_we, o_accum}, 12'h000);
    t_or;
    t_jump;
    t_skip;
    t_inc;
    conclude;
  end
endmodule : branch_increment_or_decode_tb
bind bid_core bid_chk u_chk (
  .i_core_clk(i_core_clk),
  .i_nrst(i_nrst),
  .i_insn_valid(i_insn_valid),
  .i_insn(i_insn),
  .i_pc_upper_latch(i_pc_upper_latch),
  .i_file_rdata(i_file_rdata),
  .o_file_we(o_file_we),
  .o_file_wdata(o_file_wdata),
  .o_accum(o_accum),
  .o_zero_we(o_zero_we),
  .o_zero(o_zero),
  .o_pc_load(o_pc_load),
  .o_pc(o_pc),
  .o_flush(o_flush),
  .o_busy(o_busy)
);
